// ===== sbs_burst_counter.sv
`timescale 1ns/10ps
`default_nettype none
`include "sync_burst_sram_params.svh"

module sbs_burst_counter (
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_reset,
  input  wire logic                    i_load,
  input  wire logic [`SBS_BURST_W-1:0] i_start_bits,
  input  wire logic                    i_step,
  input  wire logic                    i_interleave,
  output logic      [`SBS_BURST_W-1:0] o_addr_low,
  output logic      [`SBS_BURST_W-1:0] o_start,
  output logic      [`SBS_BURST_W-1:0] o_count
);

  sbs_pkg::burst_state_t s_r;
  sbs_pkg::burst_state_t s_nxt;

  function automatic logic [`SBS_BURST_W-1:0] burst_addr(
    input logic [`SBS_BURST_W-1:0] start,
    input logic [`SBS_BURST_W-1:0] cnt,
    input logic                    il
  );
    if (il) begin
      burst_addr = start ^ cnt;
    end else begin
      burst_addr = `SBS_BURST_W'(start + cnt);
    end
  endfunction : burst_addr

  always_comb begin
    s_nxt = s_r;
    if (i_load) begin
      s_nxt.start = i_start_bits;
      s_nxt.cnt   = `SBS_CNT_ZERO;
    end else if (i_step) begin
      // Two-bit count wraps after the fourth access
      s_nxt.cnt = `SBS_BURST_W'(s_r.cnt + `SBS_CNT_ONE);
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_addr_low = burst_addr(s_r.start, s_r.cnt, i_interleave);
  assign o_start    = s_r.start;
  assign o_count    = s_r.cnt;

endmodule : sbs_burst_counter
`default_nettype wire

// ===== sbs_bus_wire.sv
`timescale 1ns/10ps
`default_nettype none
`include "sync_burst_sram_params.svh"

// ----------------------------------------
// Shared data bus seen by master and port
// ----------------------------------------
module sbs_bus_wire (
  input  wire logic                              i_clk_sys,
  input  wire logic [`SBS_LANES*`SBS_DATA_W-1:0] i_dev_data,
  input  wire logic [`SBS_LANES-1:0]             i_dev_par,
  input  wire logic                              i_dev_oe_n,
  input  wire logic [`SBS_LANES*`SBS_DATA_W-1:0] i_mst_data,
  input  wire logic [`SBS_LANES-1:0]             i_mst_par,
  input  wire logic                              i_mst_oe_n,
  output logic      [`SBS_LANES*`SBS_DATA_W-1:0] o_data,
  output logic      [`SBS_LANES-1:0]             o_par
);
  logic [`SBS_WORD_W-1:0] last_r;

  // Released bus shows the inverse level, so a stale copy never passes
  always_comb begin
    if (!i_dev_oe_n && !i_mst_oe_n) begin
      {o_par, o_data} = 'x;
    end else if (!i_dev_oe_n) begin
      {o_par, o_data} = {i_dev_par, i_dev_data};
    end else if (!i_mst_oe_n) begin
      {o_par, o_data} = {i_mst_par, i_mst_data};
    end else begin
      {o_par, o_data} = ~last_r;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    last_r <= {o_par, o_data};
  end
endmodule : sbs_bus_wire
`default_nettype wire

// ===== sbs_lane_mem.sv
`timescale 1ns/10ps
`default_nettype none
`include "sync_burst_sram_params.svh"

module sbs_lane_mem #(
  parameter int ADDR_W = `SBS_ADDR_W,
  parameter int LANES  = `SBS_LANES,
  parameter int LANE_W = `SBS_LANE_W
) (
  input  wire logic                      i_clk_sys,
  input  wire logic                      i_we,
  input  wire logic [LANES-1:0]          i_lane_en,
  input  wire logic [ADDR_W-1:0]         i_addr,
  input  wire logic [LANES*LANE_W-1:0]   i_wdata,
  output logic      [LANES*LANE_W-1:0]   o_rdata
);

  logic [LANES*LANE_W-1:0] mem [2**ADDR_W];

  // Read returns the old word when the same address is written
  // One process for all lanes, so the array has a single writer
  always_ff @(posedge i_clk_sys) begin
    o_rdata <= mem[i_addr];
    for (int g = 0; g < LANES; g++) begin
      if (i_we && i_lane_en[g]) begin
        mem[i_addr][g*LANE_W +: LANE_W] <= i_wdata[g*LANE_W +: LANE_W];
      end
    end
  end

endmodule : sbs_lane_mem
`default_nettype wire

// ===== sbs_pkg.sv
`include "sync_burst_sram_params.svh"

package sbs_pkg;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_DESELECT,
    OP_READ,
    OP_WRITE
  } op_t;

  typedef struct packed {
    logic [`SBS_BURST_W-1:0] start;
    logic [`SBS_BURST_W-1:0] cnt;
  } burst_state_t;

  typedef struct packed {
    logic [`SBS_SYNC_W-1:0] oe_sync;
    logic [`SBS_SYNC_W-1:0] zz_sync;
    logic [`SBS_SYNC_W-1:0] mode_sync;
    logic                   oe_on;
    logic                   zz_on;
    logic                   mode_il;
    logic                   active;
    logic                   rd_v;
    logic [`SBS_WORD_W-1:0] q;
    logic                   q_oe_n;
  } port_state_t;

endpackage : sbs_pkg

// ===== sync_burst_sram_params.svh
`ifndef SYNC_BURST_SRAM_PARAMS_SVH
`define SYNC_BURST_SRAM_PARAMS_SVH

// Organisation: two byte lanes, eight data bits plus one parity bit each
`define SBS_LANES      2
`define SBS_DATA_W     8
`define SBS_LANE_W     9
`define SBS_WORD_W     18
`define SBS_ADDR_W     19
`define SBS_BURST_W    2

// Pin synchroniser depth and the two stages whose agreement counts
`define SBS_SYNC_W     3
`define SBS_SYNC_MID   1
`define SBS_SYNC_LAST  2

// Counter constants and reset values
`define SBS_CNT_ZERO   2'h0
`define SBS_CNT_ONE    2'h1
`define SBS_OE_SYNC_RST 3'h7
`define SBS_ZZ_SYNC_RST 3'h0
`define SBS_MODE_SYNC_RST 3'h7

`endif

// ===== sync_burst_sram_port.sv
// How it works
// - Burst start bits are the address LSBs
// - Selected processor strobe starts a read burst
// - Processor-strobe write happens on the next edge
// - Controller strobe with write starts write burst
// - Controller strobe without write starts read burst
// - Advance low steps counter and reads
// - Advance low with write writes next address
// - Advance high holds address, repeats the read
// - Suspended write rewrites the current address
// - Write decodes from global or gated lane enables
// - Lane enable gates its byte and parity
// - Two lanes of eight data plus parity
// - Inputs sampled on rising edge; enable/snooze/order select not
// - Data bus high impedance from power-up
// - Order select high gives interleaved XOR sequence
// - Order select low gives linear sequence
`timescale 1ns/10ps
`default_nettype none
`include "sync_burst_sram_params.svh"

module sync_burst_sram_port #(
  parameter int ADDR_W = `SBS_ADDR_W
) (
  input  wire logic                                 i_clk_sys,
  input  wire logic                                 i_reset,
  input  wire logic [ADDR_W-1:`SBS_BURST_W]         i_addr,
  input  wire logic [`SBS_BURST_W-1:0]              i_burst_start_bits,
  input  wire logic                                 i_chip_select_n,
  input  wire logic                                 i_chip_select_lo_n,
  input  wire logic                                 i_chip_select_hi_or_lo,
  input  wire logic                                 i_processor_addr_strobe_n,
  input  wire logic                                 i_controller_addr_strobe_n,
  input  wire logic                                 i_burst_advance_n,
  input  wire logic                                 i_global_write_n,
  input  wire logic                                 i_byte_write_gate_n,
  input  wire logic [`SBS_LANES-1:0]                i_lane_write_n,
  input  wire logic                                 i_output_enable_n,
  input  wire logic                                 i_snooze_request,
  input  wire logic                                 i_burst_order_sel,
  input  wire logic [`SBS_LANES*`SBS_DATA_W-1:0]    i_lane_data_bits,
  input  wire logic [`SBS_LANES-1:0]                i_lane_parity_bits,
  output logic      [`SBS_LANES*`SBS_DATA_W-1:0]    o_lane_data_bits,
  output logic      [`SBS_LANES-1:0]                o_lane_parity_bits,
  output logic                                      o_data_oe_n
);

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  function automatic logic write_active(
    input logic                  gw_n,
    input logic                  bwe_n,
    input logic [`SBS_LANES-1:0] lane_n
  );
    write_active = !gw_n || (!bwe_n && !(&lane_n));
  endfunction : write_active

  function automatic logic [`SBS_LANES-1:0] lane_enables(
    input logic                  gw_n,
    input logic                  bwe_n,
    input logic [`SBS_LANES-1:0] lane_n
  );
    if (!gw_n) begin
      lane_enables = '1;
    end else if (!bwe_n) begin
      lane_enables = ~lane_n;
    end else begin
      lane_enables = '0;
    end
  endfunction : lane_enables

  // Address one step on from the registered count
  function automatic logic [`SBS_BURST_W-1:0] burst_next(
    input logic [`SBS_BURST_W-1:0] start,
    input logic [`SBS_BURST_W-1:0] cnt,
    input logic                    il
  );
    logic [`SBS_BURST_W-1:0] nxt;
    nxt = `SBS_BURST_W'(cnt + `SBS_CNT_ONE);
    if (il) begin
      burst_next = start ^ nxt;
    end else begin
      burst_next = `SBS_BURST_W'(start + nxt);
    end
  endfunction : burst_next

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  sbs_pkg::port_state_t      s_r;
  sbs_pkg::port_state_t      s_nxt;
  sbs_pkg::op_t              op;
  logic                      sel_ok;
  logic                      proc_go;
  logic                      start;
  logic                      wr_act;
  logic [`SBS_LANES-1:0]     lane_en;
  logic                      load;
  logic                      step;
  logic [`SBS_BURST_W-1:0]   cnt_addr;
  logic [`SBS_BURST_W-1:0]   cnt_start;
  logic [`SBS_BURST_W-1:0]   cnt_count;
  logic [`SBS_BURST_W-1:0]   addr_low;
  logic [ADDR_W-1:0]         mem_addr;
  logic                      mem_we;
  logic [`SBS_WORD_W-1:0]    wdata;
  logic [`SBS_WORD_W-1:0]    rdata;

  // ----------------------------------------------------------------
  // Cycle decode
  // ----------------------------------------------------------------
  // Synchronous controls are taken straight from the bus on this clock
  assign sel_ok  = !i_chip_select_n && !i_chip_select_lo_n && i_chip_select_hi_or_lo;
  assign proc_go = !i_processor_addr_strobe_n && !i_chip_select_n;
  assign start   = proc_go || !i_controller_addr_strobe_n;
  assign wr_act  = write_active(i_global_write_n, i_byte_write_gate_n, i_lane_write_n);
  assign lane_en = lane_enables(i_global_write_n, i_byte_write_gate_n, i_lane_write_n);

  always_comb begin
    op = sbs_pkg::OP_IDLE;
    if (s_r.zz_on) begin
      op = sbs_pkg::OP_IDLE;
    end else if (start) begin
      if (!sel_ok) begin
        op = sbs_pkg::OP_DESELECT;
      end else if (proc_go) begin
        // Write control is ignored on the strobe edge itself
        op = sbs_pkg::OP_READ;
      end else if (wr_act) begin
        op = sbs_pkg::OP_WRITE;
      end else begin
        op = sbs_pkg::OP_READ;
      end
    end else if (s_r.active) begin
      // Continue or suspend; a following write lands here
      if (wr_act) begin
        op = sbs_pkg::OP_WRITE;
      end else begin
        op = sbs_pkg::OP_READ;
      end
    end
  end

  assign load     = start && sel_ok && !s_r.zz_on;
  assign step     = !start && s_r.active && !s_r.zz_on && !i_burst_advance_n;
  // An advance edge already accesses the next address, not the current one
  assign addr_low = load ? i_burst_start_bits :
                    (step ? burst_next(cnt_start, cnt_count, s_r.mode_il) : cnt_addr);
  assign mem_addr = {i_addr, addr_low};
  assign mem_we   = (op == sbs_pkg::OP_WRITE);

  // Each lane is its data byte with its parity bit on top
  for (genvar g = 0; g < `SBS_LANES; g++) begin : g_pack
    assign wdata[g*`SBS_LANE_W +: `SBS_LANE_W] =
      {i_lane_parity_bits[g], i_lane_data_bits[g*`SBS_DATA_W +: `SBS_DATA_W]};
  end

  // ----------------------------------------------------------------
  // Burst counter and storage
  // ----------------------------------------------------------------
  sbs_burst_counter u_counter (
    .i_clk_sys    (i_clk_sys),
    .i_reset      (i_reset),
    .i_load       (load),
    .i_start_bits (i_burst_start_bits),
    .i_step       (step),
    .i_interleave (s_r.mode_il),
    .o_addr_low   (cnt_addr),
    .o_start      (cnt_start),
    .o_count      (cnt_count)
  );

  sbs_lane_mem #(
    .ADDR_W (ADDR_W),
    .LANES  (`SBS_LANES),
    .LANE_W (`SBS_LANE_W)
  ) u_mem (
    .i_clk_sys (i_clk_sys),
    .i_we      (mem_we),
    .i_lane_en (lane_en),
    .i_addr    (mem_addr),
    .i_wdata   (wdata),
    .o_rdata   (rdata)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    // Output enable, snooze and order select are not tied to this clock
    s_nxt.oe_sync   = {s_r.oe_sync[`SBS_SYNC_MID], s_r.oe_sync[0], i_output_enable_n};
    s_nxt.zz_sync   = {s_r.zz_sync[`SBS_SYNC_MID], s_r.zz_sync[0], i_snooze_request};
    s_nxt.mode_sync = {s_r.mode_sync[`SBS_SYNC_MID], s_r.mode_sync[0], i_burst_order_sel};
    if (s_r.oe_sync[`SBS_SYNC_MID] == s_r.oe_sync[`SBS_SYNC_LAST]) begin
      s_nxt.oe_on = !s_r.oe_sync[`SBS_SYNC_LAST];
    end
    if (s_r.zz_sync[`SBS_SYNC_MID] == s_r.zz_sync[`SBS_SYNC_LAST]) begin
      s_nxt.zz_on = s_r.zz_sync[`SBS_SYNC_LAST];
    end
    if (s_r.mode_sync[`SBS_SYNC_MID] == s_r.mode_sync[`SBS_SYNC_LAST]) begin
      s_nxt.mode_il = s_r.mode_sync[`SBS_SYNC_LAST];
    end
    case (op)
      sbs_pkg::OP_DESELECT: s_nxt.active = 1'b0;
      sbs_pkg::OP_READ:     s_nxt.active = 1'b1;
      sbs_pkg::OP_WRITE:    s_nxt.active = 1'b1;
      sbs_pkg::OP_IDLE:     s_nxt.active = s_r.active;
      default:              s_nxt.active = 1'b0;
    endcase
    s_nxt.rd_v = (op == sbs_pkg::OP_READ);
    s_nxt.q    = rdata;
    // Drive only a finished read with enable low and no snooze
    s_nxt.q_oe_n = !(s_r.rd_v && s_r.oe_on && !s_r.zz_on);
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      s_r           <= '0;
      s_r.oe_sync   <= `SBS_OE_SYNC_RST;
      s_r.zz_sync   <= `SBS_ZZ_SYNC_RST;
      s_r.mode_sync <= `SBS_MODE_SYNC_RST;
      s_r.mode_il   <= 1'b1;
      s_r.q_oe_n    <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  for (genvar g = 0; g < `SBS_LANES; g++) begin : g_out
    assign o_lane_data_bits[g*`SBS_DATA_W +: `SBS_DATA_W] =
      s_r.q[g*`SBS_LANE_W +: `SBS_DATA_W];
    assign o_lane_parity_bits[g] = s_r.q[g*`SBS_LANE_W + `SBS_DATA_W];
  end
  assign o_data_oe_n = s_r.q_oe_n;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_power_up_hiz;
    @(posedge i_clk_sys) i_reset |=> o_data_oe_n;
  endproperty
  a_power_up_hiz: assert property (p_power_up_hiz)
    else $error("Data bus driven right after reset");

  property p_proc_start_reads;
    @(posedge i_clk_sys) disable iff (i_reset)
      (proc_go && sel_ok && !s_r.zz_on) |-> (!mem_we && load && addr_low == i_burst_start_bits);
  endproperty
  a_proc_start_reads: assert property (p_proc_start_reads)
    else $error("Processor strobe start did not read the external address");

  property p_proc_then_write;
    @(posedge i_clk_sys) disable iff (i_reset)
      (proc_go && sel_ok && !s_r.zz_on) ##1
      (start == 1'b0 && wr_act && !s_r.zz_on && i_burst_advance_n)
      |-> (mem_we && addr_low == $past(i_burst_start_bits));
  endproperty
  a_proc_then_write: assert property (p_proc_then_write)
    else $error("Write after processor strobe missed the start address");

  property p_ctrl_start_write;
    @(posedge i_clk_sys) disable iff (i_reset)
      (!proc_go && !i_controller_addr_strobe_n && sel_ok && wr_act && !s_r.zz_on)
      |-> (mem_we && addr_low == i_burst_start_bits);
  endproperty
  a_ctrl_start_write: assert property (p_ctrl_start_write)
    else $error("Controller strobe write did not begin a write burst");

  property p_ctrl_start_read;
    @(posedge i_clk_sys) disable iff (i_reset)
      (!proc_go && !i_controller_addr_strobe_n && sel_ok && !wr_act && !s_r.zz_on)
      |=> s_r.rd_v && s_r.active;
  endproperty
  a_ctrl_start_read: assert property (p_ctrl_start_read)
    else $error("Controller strobe read did not begin a read burst");

  property p_advance_steps;
    @(posedge i_clk_sys) disable iff (i_reset)
      (!start && s_r.active && !s_r.zz_on && !i_burst_advance_n)
      |=> cnt_count == `SBS_BURST_W'($past(cnt_count) + `SBS_CNT_ONE);
  endproperty
  a_advance_steps: assert property (p_advance_steps)
    else $error("Advance did not step the burst counter by one");

  property p_suspend_holds;
    @(posedge i_clk_sys) disable iff (i_reset)
      (!start && i_burst_advance_n) |=> $stable(cnt_count) && $stable(cnt_start);
  endproperty
  a_suspend_holds: assert property (p_suspend_holds)
    else $error("Suspended burst moved its address");

  property p_lane_gate;
    @(posedge i_clk_sys) disable iff (i_reset)
      mem_we |-> (i_global_write_n ? (lane_en == ~i_lane_write_n) : (&lane_en));
  endproperty
  a_lane_gate: assert property (p_lane_gate)
    else $error("Lane write enables do not follow the lane controls");

  property p_interleave;
    @(posedge i_clk_sys) disable iff (i_reset)
      s_r.mode_il |-> cnt_addr == (cnt_start ^ cnt_count);
  endproperty
  a_interleave: assert property (p_interleave)
    else $error("Interleaved order wrong");

  property p_linear;
    @(posedge i_clk_sys) disable iff (i_reset)
      !s_r.mode_il |-> cnt_addr == `SBS_BURST_W'(cnt_start + cnt_count);
  endproperty
  a_linear: assert property (p_linear)
    else $error("Linear order wrong");

  property p_deselect_hiz;
    @(posedge i_clk_sys) disable iff (i_reset)
      (start && !sel_ok && !s_r.zz_on) |-> ##2 o_data_oe_n;
  endproperty
  a_deselect_hiz: assert property (p_deselect_hiz)
    else $error("Deselect left the data bus driven");

  property p_snooze_hiz;
    @(posedge i_clk_sys) disable iff (i_reset)
      s_r.zz_on |-> !mem_we ##1 o_data_oe_n;
  endproperty
  a_snooze_hiz: assert property (p_snooze_hiz)
    else $error("Snooze did not tri-state or stop writes");

  property p_drive_needs_read;
    @(posedge i_clk_sys) disable iff (i_reset)
      !o_data_oe_n |-> $past(s_r.oe_on) && $past(s_r.rd_v);
  endproperty
  a_drive_needs_read: assert property (p_drive_needs_read)
    else $error("Bus driven without a read and enable low");

  c_write_burst: cover property (@(posedge i_clk_sys) disable iff (i_reset)
    (mem_we && load) ##1 (mem_we && step)[*3]);
  c_read_drive: cover property (@(posedge i_clk_sys) disable iff (i_reset)
    (op == sbs_pkg::OP_READ) ##2 !o_data_oe_n);
  c_proc_write: cover property (@(posedge i_clk_sys) disable iff (i_reset)
    (proc_go && sel_ok) ##1 mem_we);
  c_snooze: cover property (@(posedge i_clk_sys) disable iff (i_reset)
    $rose(s_r.zz_on));

endmodule : sync_burst_sram_port
`default_nettype wire

// ===== sync_burst_sram_port_test.sv
`timescale 1ns/10ps
`default_nettype none
`include "sync_burst_sram_params.svh"

module sync_burst_sram_port_test;
  localparam logic [2:0] SEL = 3'h1;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [2:0]  sel_v = SEL;
  logic        proc_n = 1'b1;
  logic        ctrl_n = 1'b1;
  logic        adv_n = 1'b1;
  logic [3:0]  wc = 4'hf;
  logic [1:0]  sbits = 2'h0;
  logic        oe_n = 1'b1;
  logic        zz = 1'b0;
  logic        order = 1'b1;
  logic [17:0] mst_w = 18'h0;
  logic        mst_oe_n = 1'b1;
  logic [15:0] dq_o;
  logic [1:0]  dqp_o;
  logic        dq_oe_n;
  logic [15:0] w_d;
  logic [1:0]  w_p;
  logic [17:0] mem [4];
  int          n_errors = 0;
  int          total_checks = 0;

  always #5 clk = ~clk;

  sync_burst_sram_port u_dut (
    .i_clk_sys                 (clk),
    .i_reset                   (rst),
    .i_addr                    (17'h000a5),
    .i_burst_start_bits        (sbits),
    .i_chip_select_n           (sel_v[2]),
    .i_chip_select_lo_n        (sel_v[1]),
    .i_chip_select_hi_or_lo    (sel_v[0]),
    .i_processor_addr_strobe_n (proc_n),
    .i_controller_addr_strobe_n(ctrl_n),
    .i_burst_advance_n         (adv_n),
    .i_global_write_n          (wc[3]),
    .i_byte_write_gate_n       (wc[2]),
    .i_lane_write_n            (wc[1:0]),
    .i_output_enable_n         (oe_n),
    .i_snooze_request          (zz),
    .i_burst_order_sel         (order),
    .i_lane_data_bits          (w_d),
    .i_lane_parity_bits        (w_p),
    .o_lane_data_bits          (dq_o),
    .o_lane_parity_bits        (dqp_o),
    .o_data_oe_n               (dq_oe_n)
  );

  sbs_bus_wire u_wire (
    .i_clk_sys (clk),
    .i_dev_data(dq_o),
    .i_dev_par (dqp_o),
    .i_dev_oe_n(dq_oe_n),
    .i_mst_data({mst_w[16:9], mst_w[7:0]}),
    .i_mst_par ({mst_w[17], mst_w[8]}),
    .i_mst_oe_n(mst_oe_n),
    .o_data    (w_d),
    .o_par     (w_p)
  );

  // ----------------------------------------
  // Checking and verdict
  // ----------------------------------------
  task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : give_verdict

  task automatic settle(input logic o, input logic m);
    oe_n <= o;
    order <= m;
    repeat (5) @(posedge clk);
  endtask : settle

  // ----------------------------------------
  // One start plus four continue edges
  // ----------------------------------------
  // Lane g of a word is {parity g, byte g}; reads land two edges later
  task automatic burst(input logic proc, input logic [2:0] sel, input logic [1:0] s,
                       input logic [3:0] c, input logic [3:0] burst_advance_n, input logic on,
                       input logic [17:0] base);
    int          j;
    int          g;
    logic [1:0]  cnt;
    logic [1:0]  a;
    logic [1:0]  mask;
    logic        wr;
    logic [17:0] w;
    logic [17:0] expw [5];
    logic        rdf [5];
    wr = !c[3] || (!c[2] && c[1:0] != 2'h3);
    mask = !c[3] ? 2'h3 : ~c[1:0];
    cnt = 2'h0;
    for (j = 0; j < 8; j++) begin
      @(posedge clk);
      w = base + 18'(j) * 18'h00b3d;
      if (j == 0) begin
        sel_v <= sel;
        proc_n <= !proc;
        ctrl_n <= proc;
        sbits <= s;
      end else begin
        proc_n <= 1'b1;
        ctrl_n <= 1'b1;
        adv_n <= (j < 5) ? burst_advance_n[j-1] : 1'b1;
      end
      wc <= (j < 5) ? c : 4'hf;
      mst_oe_n <= !(wr && j < 5);
      mst_w <= w;
      if (j < 5) begin
        if (j > 0 && !burst_advance_n[j-1]) begin
          cnt = cnt + 2'h1;
        end
        a = (j == 0) ? s : (order ? s ^ cnt : s + cnt);
        expw[j] = mem[a];
        rdf[j] = !wr || (j == 0 && proc);
        for (g = 0; g < 2; g++) begin
          if (wr && !rdf[j] && mask[g]) begin
            mem[a][9*g +: 9] = w[9*g +: 9];
          end
        end
      end
      if (j >= 2 && j < 7) begin
        #1;
        if (on && rdf[j-2]) begin
          chk(18'(dq_oe_n), 18'h0);
          chk({w_p[1], w_d[15:8], w_p[0], w_d[7:0]}, expw[j-2]);
        end else begin
          chk(18'(dq_oe_n), 18'h1);
        end
      end
    end
  endtask : burst

  initial begin
    #20000;
    n_errors++;
    give_verdict();
  end

  initial begin
    repeat (5) @(posedge clk);
    #1 chk(18'(dq_oe_n), 18'h1);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk(18'(dq_oe_n), 18'h1);
    burst(1'b0, SEL, 2'h1, 4'h0, 4'h0, 1'b0, 18'h10000);
    burst(1'b0, SEL, 2'h2, 4'hf, 4'h0, 1'b0, 18'h0);
    settle(1'b0, 1'b1);
    burst(1'b1, SEL, 2'h2, 4'hf, 4'h0, 1'b1, 18'h0);
    burst(1'b0, SEL, 2'h3, 4'hf, 4'h0, 1'b1, 18'h0);
    settle(1'b0, 1'b0);
    burst(1'b1, SEL, 2'h3, 4'hf, 4'h4, 1'b1, 18'h0);
    settle(1'b1, 1'b0);
    burst(1'b1, SEL, 2'h2, 4'ha, 4'h5, 1'b0, 18'h2a000);
    burst(1'b0, SEL, 2'h0, 4'hb, 4'h0, 1'b0, 18'h3f000);
    burst(1'b0, SEL, 2'h0, 4'hc, 4'h0, 1'b0, 18'h3f000);
    settle(1'b0, 1'b1);
    burst(1'b1, SEL, 2'h0, 4'hf, 4'h0, 1'b1, 18'h0);
    burst(1'b0, 3'h2, 2'h0, 4'hf, 4'h0, 1'b0, 18'h0);
    burst(1'b1, 3'h5, 2'h0, 4'hf, 4'h0, 1'b0, 18'h0);
    zz <= 1'b1;
    repeat (5) @(posedge clk);
    burst(1'b1, SEL, 2'h0, 4'hf, 4'h0, 1'b0, 18'h0);
    zz <= 1'b0;
    give_verdict();
  end
endmodule : sync_burst_sram_port_test
`default_nettype wire
